//--- tbps_map.svh
`ifndef TBPS_MAP_SVH
`define TBPS_MAP_SVH
// ==================================================
// register offsets
`define REG_CTRL     8'h00
`define REG_TLEN     8'h04
`define REG_PINTV    8'h08
`define REG_CMD      8'h0c
`define REG_STAT     8'h10
`define REG_ELAPSED  8'h14
// ==================================================
// control fields
`define F_TIMED      0
`define F_TRIG       2:1
`define F_BAUD       5:3
`define F_PAR        7:6
`define F_CRLF       8
// command bits, one-shot on write
`define C_VOL_UP     0
`define C_VOL_DN     1
`define C_TLEN       5:2
`define C_PINT       9:6
`define C_CTRL_PRN   10
`define C_RSLT_PRN   11
`define C_FLUSH      12
// ==================================================
// reset values and limits
`define CTRL_RST     9'h000
`define VOL_RST      3'h3
`define VOL_MAX      3'h6
`define TLEN_HR_RST  8'h00
`define TLEN_MN_RST  6'h0f
`define TLEN_HR_MAX  8'hc8
`define PINT_HR_RST  8'h01
`define PINT_MN_RST  6'h00
`define PINT_HR_MAX  8'h17
`define MN_LAST      6'h3b
`define SEC_LAST     6'h3b
`define MIN_PER_HR   14'h003c
// ==================================================
// timing, clock rate in hertz
`define CLK_HZ       10000000
`define BAUD_DIV(r)  (`CLK_HZ / (r))
`define CHAR_CR      8'h0d
`define CHAR_LF      8'h0a
`define STORE_DEPTH  64
`endif

//--- tbps_pkg.sv
package tbps_pkg;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h3,
        TX_PAR   = 3'h2,
        TX_STOP  = 3'h6
    } tx_state_t;
    typedef enum logic [1:0] {
        TRIG_OFF   = 2'h0,
        TRIG_ERROR = 2'h1,
        TRIG_TIMED = 2'h2
    } trigger_t;
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ODD  = 2'h1,
        PAR_EVEN = 2'h2
    } parity_t;
    typedef struct packed {
        logic       eol;
        logic [7:0] data;
    } print_char_t;
    typedef struct packed {
        logic bit_err;
        logic bipolar_violation;
        logic frame_err;
        logic crc_err;
        logic slip;
    } error_events_t;
    typedef struct packed {
        logic [7:0] hr;
        logic [5:0] mn;
    } hm_t;
endpackage

//--- test_timer_print_scheduler.sv
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`include "tbps_map.svh"
module test_timer_print_scheduler #(
    parameter int SEC_CYCLES = `CLK_HZ
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic [7:0]             addr,
    input  wire logic [31:0]            wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic [31:0]                 rdata,
    input  wire tbps_pkg::error_events_t err,
    input  wire logic                   printer_present,
    input  wire tbps_pkg::print_char_t  src,
    input  wire logic                   src_valid,
    output logic                        src_ready,
    output logic                        txd,
    output logic [2:0]                  volume_level,
    output logic [5:0]                  volume_boxes,
    output logic                        beep,
    output logic                        ctrl_print_req,
    output logic                        rslt_print_req,
    output logic                        ctrl_ack_flash,
    output logic                        rslt_ack_flash,
    output logic                        print_abort,
    output logic                        results_clear,
    output logic                        accumulate,
    output logic                        test_ended
);
    import tbps_pkg::*;

    function automatic hm_t hm_adj(input hm_t v, input logic [3:0] c,
                                   input logic [7:0] hmax);
        hm_t r;
        r = v;
        if (c[0] && v.hr < hmax)
            r.hr = v.hr + 8'h01;
        else if (c[1] && v.hr != 8'h00 && !(v.hr == 8'h01 && v.mn == 6'h00))
            r.hr = v.hr - 8'h01;
        // minimum total of one minute is guarded against the new hour
        if (c[2] && v.mn < `MN_LAST)
            r.mn = v.mn + 6'h01;
        else if (c[3] && v.mn != 6'h00 && !(r.hr == 8'h00 && v.mn == 6'h01))
            r.mn = v.mn - 6'h01;
        return r;
    endfunction

    // ==================================================
    // register writes
    logic [8:0]  ctrl_q;
    logic [2:0]  vol_q;
    hm_t         tlen_q, pint_q;
    wire         ctrl_wr = wr && addr == `REG_CTRL;
    wire         cmd_wr  = wr && addr == `REG_CMD;
    wire [12:0]  cmd     = cmd_wr ? wdata[12:0] : 13'h0000;
    wire         flush   = cmd[`C_FLUSH];
    wire         vol_up  = cmd[`C_VOL_UP];
    wire         vol_dn  = cmd[`C_VOL_DN];
    wire         timed   = ctrl_q[`F_TIMED];
    wire trigger_t trig  = trigger_t'(ctrl_q[`F_TRIG]);
    wire parity_t  par   = parity_t'(ctrl_q[`F_PAR]);
    wire         restart = ctrl_wr && wdata[`F_TIMED] && !timed;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RST;
            vol_q  <= `VOL_RST;
            tlen_q <= '{hr: `TLEN_HR_RST, mn: `TLEN_MN_RST};
            pint_q <= '{hr: `PINT_HR_RST, mn: `PINT_MN_RST};
        end else begin
            if (ctrl_wr)
                ctrl_q <= wdata[8:0];
            if (vol_up && vol_q < `VOL_MAX)
                vol_q <= vol_q + 3'h1;
            else if (vol_dn && vol_q != 3'h0)
                vol_q <= vol_q - 3'h1;
            tlen_q <= hm_adj(tlen_q, cmd[`C_TLEN], `TLEN_HR_MAX);
            pint_q <= hm_adj(pint_q, cmd[`C_PINT], `PINT_HR_MAX);
        end
    end

    // ==================================================
    // second and minute timebase
    logic [23:0] sec_cnt_q;
    logic [5:0]  min_sec_q, test_sec_q;
    logic [10:0] pint_min_q;
    logic [13:0] elapsed_q;
    logic        beep_done_q, perr_seen_q, ended_q;
    wire sec_tick = sec_cnt_q == 24'(SEC_CYCLES - 1);
    wire min_tick = sec_tick && min_sec_q == `SEC_LAST;
    wire test_min = sec_tick && test_sec_q == `SEC_LAST;
    wire [13:0] tlen_tot = 14'(tlen_q.hr) * `MIN_PER_HR + 14'(tlen_q.mn);
    wire [13:0] pint_tot = 14'(pint_q.hr) * `MIN_PER_HR + 14'(pint_q.mn);
    wire        err_any  = |err;
    wire        perr     = err.bit_err | err.bipolar_violation | err.frame_err | err.crc_err;
    // an error on the tick cycle belongs to the new second
    wire err_beep  = err_any && (!beep_done_q || sec_tick);
    wire auto_err  = sec_tick && perr_seen_q && trig == TRIG_ERROR;
    wire pint_due  = min_tick && 14'(pint_min_q) + 14'h0001 >= pint_tot;
    wire auto_tmd  = pint_due && trig == TRIG_TIMED;
    wire reach_end = timed && !ended_q && elapsed_q >= tlen_tot;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sec_cnt_q   <= 24'h000000;
            min_sec_q   <= 6'h00;
            pint_min_q  <= 11'h000;
            beep_done_q <= 1'b0;
            perr_seen_q <= 1'b0;
        end else begin
            sec_cnt_q   <= sec_tick ? 24'h000000 : sec_cnt_q + 24'h000001;
            if (sec_tick)
                min_sec_q <= min_tick ? 6'h00 : min_sec_q + 6'h01;
            // free running, the test mode never touches it
            if (min_tick)
                pint_min_q <= pint_due ? 11'h000 : pint_min_q + 11'h001;
            beep_done_q <= err_any || (beep_done_q && !sec_tick);
            perr_seen_q <= perr || (perr_seen_q && !sec_tick);
        end
    end

    // ==================================================
    // test duration
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            test_sec_q <= 6'h00;
            elapsed_q  <= 14'h0000;
            ended_q    <= 1'b0;
        end else if (restart) begin
            test_sec_q <= 6'h00;
            elapsed_q  <= 14'h0000;
            ended_q    <= 1'b0;
        end else begin
            if (reach_end)
                ended_q <= 1'b1;
            // continuous mode never sets ended_q, so the count runs on, elapsed_q holding at 3fff
            if (sec_tick && !ended_q)
                test_sec_q <= test_min ? 6'h00 : test_sec_q + 6'h01;
            if (test_min && !ended_q && elapsed_q != 14'h3fff)
                elapsed_q <= elapsed_q + 14'h0001;
        end
    end
    // ==================================================
    // print store and serial port
    print_char_t store_mem [0:`STORE_DEPTH-1];
    logic [5:0]  wr_ptr_q, rd_ptr_q;
    logic [6:0]  cnt_q;
    logic        pp_s1_q, pp_s2_q, lf_pend_q;
    tx_state_t   st_q, st_d;
    logic [15:0] bcnt_q, bcnt_d;
    logic [2:0]  idx_q, idx_d;
    logic [7:0]  sh_q, sh_d;
    logic        txd_d, lf_d;
    wire         take     = src_valid && src_ready;
    wire         to_store = take && !pp_s2_q;
    wire         tx_free  = st_q == TX_IDLE && !lf_pend_q;
    wire         drain    = pp_s2_q && cnt_q != 7'h00 && tx_free && !flush;
    wire         start_ch = drain || (take && pp_s2_q);
    wire print_char_t ch  = drain ? store_mem[rd_ptr_q] : src;
    wire [15:0] div = ctrl_q[`F_BAUD] == 3'h0 ? 16'(`BAUD_DIV(300)) :
                      ctrl_q[`F_BAUD] == 3'h1 ? 16'(`BAUD_DIV(1200)) :
                      ctrl_q[`F_BAUD] == 3'h2 ? 16'(`BAUD_DIV(2400)) :
                      ctrl_q[`F_BAUD] == 3'h3 ? 16'(`BAUD_DIV(4800)) :
                                                16'(`BAUD_DIV(9600));
    wire        no_par   = par != PAR_ODD && par != PAR_EVEN;
    wire [2:0]  last_idx = no_par ? 3'h7 : 3'h6;
    wire        par_bit  = par == PAR_ODD ? ~^sh_q[6:0] : ^sh_q[6:0];
    wire        baud_end = bcnt_q == div - 16'h0001;
    wire [2:0]  idx_nx   = idx_q + 3'h1;
    wire        rdy_d    = !flush && !take && (pp_s2_q
                           ? (tx_free && cnt_q == 7'h00 && !drain)
                           : cnt_q < 7'(`STORE_DEPTH - 2));
    always_comb begin
        st_d   = st_q;
        idx_d  = idx_q;
        sh_d   = sh_q;
        lf_d   = lf_pend_q;
        txd_d  = txd;
        bcnt_d = baud_end ? 16'h0000 : bcnt_q + 16'h0001;
        case (st_q)
            TX_IDLE: begin
                bcnt_d = 16'h0000;
                txd_d  = 1'b1;
                if (lf_pend_q) begin
                    st_d  = TX_START;
                    sh_d  = `CHAR_LF;
                    lf_d  = 1'b0;
                    txd_d = 1'b0;
                end else if (start_ch) begin
                    st_d  = TX_START;
                    sh_d  = ch.eol ? `CHAR_CR : ch.data;
                    lf_d  = ch.eol && ctrl_q[`F_CRLF];
                    txd_d = 1'b0;
                end
            end
            TX_START: if (baud_end) begin
                st_d  = TX_DATA;
                idx_d = 3'h0;
                txd_d = sh_q[0];
            end
            TX_DATA: if (baud_end) begin
                if (idx_q == last_idx) begin
                    st_d  = no_par ? TX_STOP : TX_PAR;
                    txd_d = no_par ? 1'b1 : par_bit;
                end else begin
                    idx_d = idx_nx;
                    txd_d = sh_q[idx_nx];
                end
            end
            TX_PAR: if (baud_end) begin
                st_d  = TX_STOP;
                txd_d = 1'b1;
            end
            TX_STOP: if (baud_end)
                st_d = TX_IDLE;
            default: begin
                st_d  = TX_IDLE;
                txd_d = 1'b1;
            end
        endcase
        if (flush) begin
            st_d  = TX_IDLE;
            lf_d  = 1'b0;
            txd_d = 1'b1;
        end
    end
    // storage array carries no reset on purpose, count says what is valid
    always_ff @(posedge clk_sys) begin
        if (to_store)
            store_mem[wr_ptr_q] <= src;
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pp_s1_q   <= 1'b0;
            pp_s2_q   <= 1'b0;
            wr_ptr_q  <= 6'h00;
            rd_ptr_q  <= 6'h00;
            cnt_q     <= 7'h00;
            st_q      <= TX_IDLE;
            bcnt_q    <= 16'h0000;
            idx_q     <= 3'h0;
            sh_q      <= 8'h00;
            lf_pend_q <= 1'b0;
            txd       <= 1'b1;
            src_ready <= 1'b0;
        end else begin
            pp_s1_q   <= printer_present;
            pp_s2_q   <= pp_s1_q;
            wr_ptr_q  <= flush ? 6'h00 : wr_ptr_q + 6'(to_store);
            rd_ptr_q  <= flush ? 6'h00 : rd_ptr_q + 6'(drain);
            cnt_q     <= flush ? 7'h00
                         : cnt_q + 7'(to_store) - 7'(drain);
            st_q      <= st_d;
            bcnt_q    <= bcnt_d;
            idx_q     <= idx_d;
            sh_q      <= sh_d;
            lf_pend_q <= lf_d;
            txd       <= txd_d;
            src_ready <= rdy_d;
        end
    end

    // ==================================================
    // front panel outputs and read back
    wire [31:0] stat = {27'h0, pp_s2_q, st_q != TX_IDLE,
                        cnt_q != 7'h00, ended_q, !ended_q};
    wire [31:0] rmux = addr == `REG_CTRL    ? {23'h0, ctrl_q} :
                       addr == `REG_TLEN    ? {18'h0, tlen_q} :
                       addr == `REG_PINTV   ? {18'h0, pint_q} :
                       addr == `REG_STAT    ? stat :
                       addr == `REG_ELAPSED ? {18'h0, elapsed_q} :
                                              32'h00000000;
    wire [5:0] boxes_d;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_box
            assign boxes_d[gi] = vol_q > 3'(gi);
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata          <= 32'h00000000;
            volume_level   <= `VOL_RST;
            volume_boxes   <= 6'h00;
            beep           <= 1'b0;
            ctrl_print_req <= 1'b0;
            rslt_print_req <= 1'b0;
            ctrl_ack_flash <= 1'b0;
            rslt_ack_flash <= 1'b0;
            print_abort    <= 1'b0;
            results_clear  <= 1'b0;
            accumulate     <= 1'b1;
            test_ended     <= 1'b0;
        end else begin
            rdata          <= rd ? rmux : 32'h00000000;
            volume_level   <= vol_q;
            volume_boxes   <= boxes_d;
            beep           <= vol_up || vol_dn || err_beep;
            ctrl_print_req <= cmd[`C_CTRL_PRN];
            // trigger off leaves only the manual request
            rslt_print_req <= cmd[`C_RSLT_PRN] || auto_err
                              || auto_tmd;
            ctrl_ack_flash <= cmd[`C_CTRL_PRN];
            rslt_ack_flash <= cmd[`C_RSLT_PRN];
            print_abort    <= flush;
            results_clear  <= restart;
            accumulate     <= restart || !(ended_q || reach_end);
            test_ended     <= !restart && (ended_q || reach_end);
        end
    end

    // ==================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    vol_range_a: assert property (volume_level <= `VOL_MAX)
        else $error("volume level above six");
    box_count_a: assert property ($countones(volume_boxes) == vol_q
        || $changed(vol_q) || !$past(rst_b))
        else $error("box count differs from level");
    vol_beep_a: assert property (vol_up |=> beep ##1 !beep || $past(vol_up)
        || $past(err_beep))
        else $error("volume step without one beep");
    err_beep_a: assert property (err_any && !beep_done_q |=> beep)
        else $error("errored second gave no beep");
    restart_a: assert property (restart |=> results_clear && accumulate
        && elapsed_q == 14'h0000)
        else $error("timed switch did not restart");
    keep_run_a: assert property (ctrl_wr && !wdata[`F_TIMED] && timed
        && !ended_q |=> !results_clear && !ended_q)
        else $error("continuous switch disturbed test");
    tlen_rng_a: assert property (tlen_tot >= 14'h0001
        && tlen_q.hr <= `TLEN_HR_MAX)
        else $error("test length out of range");
    ack_once_a: assert property (cmd[`C_RSLT_PRN] |=> rslt_ack_flash
        && rslt_print_req)
        else $error("results request not acknowledged");
    flush_a: assert property (flush |=> cnt_q == 7'h00 && st_q == TX_IDLE
        && print_abort ##1 txd)
        else $error("flush left data or printout");
    trig_off_a: assert property (trig == TRIG_OFF && !cmd[`C_RSLT_PRN]
        |=> !rslt_print_req)
        else $error("automatic printout while trigger off");
    start_bit_a: assert property (st_q == TX_START |-> !txd)
        else $error("start bit not low");
endmodule // test_timer_print_scheduler

//--- serial_printer_model.sv
`timescale 1ns/1ps
// ====================================
// serial printer, samples each bit mid cell
module serial_printer_model #(
    parameter int DIV = 1041
) (
    input  wire logic       clk_sys,
    input  wire logic       txd,
    input  wire logic       attached,
    output logic            printer_present,
    output logic [8:0]      rx_word,
    output logic            rx_valid
);
    assign printer_present = attached;
    initial begin
        rx_valid = 1'b0;
        rx_word = 9'h000;
        forever begin
            @(negedge txd);
            repeat (DIV / 2) @(posedge clk_sys);
            // nine cells after start, stop kept in bit 8
            for (int i = 0; i < 9; i++) begin
                repeat (DIV) @(posedge clk_sys);
                rx_word[i] <= txd;
            end
            rx_valid <= 1'b1;
            @(posedge clk_sys);
            rx_valid <= 1'b0;
        end
    end
endmodule // serial_printer_model

//--- testbench.sv
`timescale 1ns/1ps
`include "tbps_map.svh"
// ====================================
// bench top
module testbench;
    import tbps_pkg::*;
    localparam int SEC = 20;
    localparam int MIN = 60 * SEC;
    localparam int DIV = 10000000 / 9600;
    logic          clk_sys, rst_b, wr, rd, rd_q;
    logic [7:0]    addr;
    logic [31:0]   wdata, rdata, rnd;
    error_events_t err;
    print_char_t   src;
    logic          src_valid, src_ready, txd, attached, printer_present;
    logic [2:0]    volume_level;
    logic [5:0]    volume_boxes;
    logic          beep, ctrl_print_req, rslt_print_req, ctrl_ack_flash;
    logic          rslt_ack_flash, print_abort, results_clear;
    logic          accumulate, test_ended, rx_valid;
    logic [8:0]    rx_word;
    logic [6:0]    pl;
    logic [63:0]   e;
    logic [63:0]   q_rd[$];
    logic [8:0]    q_rx[$];
    int            n_errors, cmp_count, k;
    int            cnt[7];

    test_timer_print_scheduler #(.SEC_CYCLES(SEC))
        test_timer_print_scheduler_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .err(err), .src(src),
        .printer_present(printer_present), .src_valid(src_valid),
        .src_ready(src_ready), .txd(txd), .volume_level(volume_level),
        .volume_boxes(volume_boxes), .beep(beep),
        .ctrl_print_req(ctrl_print_req), .rslt_print_req(rslt_print_req),
        .ctrl_ack_flash(ctrl_ack_flash), .rslt_ack_flash(rslt_ack_flash),
        .print_abort(print_abort), .results_clear(results_clear),
        .accumulate(accumulate), .test_ended(test_ended));
    serial_printer_model #(.DIV(DIV)) serial_printer_model_i (
        .clk_sys(clk_sys), .txd(txd), .attached(attached),
        .printer_present(printer_present), .rx_word(rx_word),
        .rx_valid(rx_valid));
    // pulse counts: beep, ctrl/rslt req, ctrl/rslt ack, abort, clear
    assign pl = {results_clear, print_abort, rslt_ack_flash, ctrl_ack_flash,
                 rslt_print_req, ctrl_print_req, beep};

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ====================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // expected frame: stop bit over the eight cells
    function automatic logic [8:0] frm(input logic [7:0] c, input int p);
        if (p == 1)
            return {1'b1, ~^c[6:0], c[6:0]};
        if (p == 2)
            return {1'b1, ^c[6:0], c[6:0]};
        return {1'b1, c};
    endfunction
    task automatic check(input string w, input logic [31:0] s,
                         input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", w, x, s);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic cmd(input int b);
        wr_reg(`REG_CMD, 32'h1 << b);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] x);
        q_rd.push_back({m, x});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // cleared off the edge so the monitor never races it
    task automatic zero;
        @(negedge clk_sys);
        cnt = '{default: 0};
        @(posedge clk_sys);
    endtask
    task automatic pulse_err(input logic [4:0] v);
        err <= v;
        @(posedge clk_sys);
        err <= '0;
        @(posedge clk_sys);
    endtask
    task automatic send(input print_char_t c);
        src <= c;
        src_valid <= 1'b1;
        k = 0;
        @(posedge clk_sys);
        while (src_ready !== 1'b1 && k++ < 30000)
            @(posedge clk_sys);
        src_valid <= 1'b0;
        src <= ~c;
        @(posedge clk_sys);
    endtask
    task automatic wait_rx;
        k = 0;
        // a line end with cr lf takes two whole frames
        while (q_rx.size() != 0 && k++ < 24000)
            @(posedge clk_sys);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ====================================
    // monitor
    always @(posedge clk_sys) begin
        rd_q <= rd;
        for (int i = 0; i < 7; i++)
            cnt[i] += int'(pl[i]);
        if (rd_q === 1'b1) begin
            e = q_rd.pop_front();
            check("rdata", rdata & e[63:32], e[31:0]);
        end
        if (rx_valid === 1'b1)
            check("char", 32'(rx_word), 32'(q_rx.pop_front()));
    end
    initial begin
        idle(90000);
        n_errors++;
        end_sim;
    end
    // ====================================
    // tests
    initial begin
        {rst_b, wr, rd, src_valid, attached} = '0;
        addr = '0;
        wdata = '0;
        err = '0;
        src = '0;
        rnd = 32'd32;
        {n_errors, cmp_count} = '0;
        cnt = '{default: 0};
        idle(8);
        rst_b <= 1'b1;
        idle(2);
        check("boxes", volume_boxes, 6'h07);
        rd_reg(`REG_CTRL, '1, 32'h0);
        rd_reg(`REG_TLEN, '1, 32'h00f);
        rd_reg(`REG_PINTV, '1, 32'h040);
        rd_reg(`REG_CMD, '1, 32'h0);
        rd_reg(8'h20, '1, 32'h0);
        zero;
        repeat (4) cmd(`C_VOL_UP);
        check("level", volume_level, 3'h6);
        check("boxes", volume_boxes, 6'h3f);
        repeat (7) cmd(`C_VOL_DN);
        idle(2);
        check("boxes", volume_boxes, 6'h00);
        check("beeps", cnt[0], 11);
        $display("test volume done");
        cmd(3);
        repeat (15) cmd(5);
        rd_reg(`REG_TLEN, '1, 32'h001);
        cmd(2);
        rd_reg(`REG_TLEN, '1, 32'h041);
        repeat (210) cmd(2);
        repeat (65) cmd(4);
        rd_reg(`REG_TLEN, '1, 32'h323b);
        repeat (210) cmd(3);
        repeat (65) cmd(5);
        rd_reg(`REG_TLEN, '1, 32'h001);
        repeat (30) cmd(6);
        repeat (70) cmd(8);
        rd_reg(`REG_PINTV, '1, 32'h5fb);
        repeat (30) cmd(7);
        repeat (70) cmd(9);
        rd_reg(`REG_PINTV, '1, 32'h001);
        $display("test lengths done");
        zero;
        cmd(10);
        cmd(11);
        idle(2);
        check("requests", cnt[1] + cnt[2], 2);
        check("acks", cnt[3] + cnt[4], 2);
        idle(MIN);
        zero;
        fork
            idle(2 * MIN - 2);
            begin
                wr_reg(`REG_CTRL, 32'h005);
                idle(MIN / 2);
                wr_reg(`REG_CTRL, 32'h004);
                idle(MIN);
                check("ended", test_ended, 1'b0);
                check("accum", accumulate, 1'b1);
            end
        join
        idle(2);
        check("auto prints", cnt[2], 2);
        check("clears", cnt[6], 1);
        zero;
        wr_reg(`REG_CTRL, 32'h001);
        idle(MIN / 2);
        check("ended", test_ended, 1'b0);
        idle(MIN);
        check("ended", test_ended, 1'b1);
        check("accum", accumulate, 1'b0);
        check("auto prints", cnt[2], 0);
        check("clears", cnt[6], 1);
        $display("test duration done");
        wr_reg(`REG_CTRL, 32'h002);
        pulse_err(5'h02);
        k = 0;
        while (rslt_print_req !== 1'b1 && k++ < 60)
            @(posedge clk_sys);
        zero;
        repeat (3) begin
            rnd = xs(rnd);
            pulse_err({rnd[3:0] | 4'h1, rnd[4]});
        end
        idle(2 * SEC);
        check("beeps", cnt[0], 1);
        check("err prints", cnt[2], 1);
        zero;
        pulse_err(5'h01);
        idle(2 * SEC);
        check("beeps", cnt[0], 1);
        check("err prints", cnt[2], 0);
        $display("test errors done");
        wr_reg(`REG_CTRL, 32'h020);
        zero;
        send({1'b0, rnd[15:8]});
        idle(2);
        rd_reg(`REG_STAT, 32'h14, 32'h04);
        cmd(12);
        rd_reg(`REG_STAT, 32'h04, 32'h00);
        check("abort", cnt[5], 1);
        attached <= 1'b1;
        idle(4);
        for (int p = 0; p < 3; p++) begin
            wr_reg(`REG_CTRL, 32'h120 | (32'(p) << 6));
            rnd = xs(rnd);
            q_rx.push_back(frm(rnd[7:0], p));
            send({1'b0, rnd[7:0]});
            wait_rx;
        end
        q_rx.push_back(frm(8'h0d, 2));
        q_rx.push_back(frm(8'h0a, 2));
        send({1'b1, 8'h00});
        wait_rx;
        wr_reg(`REG_CTRL, 32'h020);
        q_rx.push_back(frm(8'h0d, 0));
        send({1'b1, 8'h00});
        wait_rx;
        check("left", q_rx.size(), 0);
        $display("test serial done");
        end_sim;
    end
endmodule // testbench
